//--- fdm_regs.vh
/*
 * Register offsets, field positions, reset values and timing counts for the
 * fault detection manager. Assumes a 125 MHz core clock and word-aligned
 * AHB-Lite register access.
 */
`ifndef FDM_REGS_VH
`define FDM_REGS_VH

// Byte offsets of the register words.
`define FDM_SUPPLY_STATUS_OFS 8'h00
`define FDM_LIN_STATUS_OFS 8'h04
`define FDM_HIGH_SIDE_STATUS_OFS 8'h08
`define FDM_WATCHDOG_STATUS_OFS 8'h0c
`define FDM_INT_SOURCE_OFS 8'h10
`define FDM_INT_MASK_OFS 8'h14
`define FDM_HIGH_SIDE_CTRL_OFS 8'h18
`define FDM_MODE_CTRL_OFS 8'h1c
`define FDM_EVENT_STATUS_OFS 8'h20
`define FDM_EVENT_MASK_OFS 8'h24
`define FDM_STATE_OFS 8'h28

// Supply status register fields.
`define FDM_BATTERY_LOSS_BIT 0
`define FDM_REG_THERMAL_WARN_BIT 1
`define FDM_SUPPLY_UNDER_BIT 2
`define FDM_SUPPLY_OVER_BIT 3

// LIN status register fields.
`define FDM_LIN_OVERHEAT_BIT 1
`define FDM_TX_STUCK_BIT 2
`define FDM_RX_SHORT_BIT 3

// High-side status register fields.
`define FDM_D1_CURLIM_BIT 0
`define FDM_D1_OPEN_BIT 1
`define FDM_D2_CURLIM_BIT 2
`define FDM_D2_OPEN_BIT 3

// Watchdog status register fields.
`define FDM_WD_CFG_ERR_BIT 2
`define FDM_WD_TIMEOUT_BIT 3

// Interrupt mask register fields (one enable per interrupt group).
`define FDM_MASK_HS_BIT 0
`define FDM_MASK_LIN_BIT 1
`define FDM_MASK_SUPPLY_BIT 2

// Mode control register fields.
`define FDM_MODE_LSB 0
`define FDM_HV_SHUTDOWN_EN_BIT 3

// Interrupt source codes.
`define FDM_SRC_NONE 4'h0
`define FDM_SRC_HS 4'h2
`define FDM_SRC_LIN 4'h4
`define FDM_SRC_SUPPLY 4'h5

// Operating mode encodings.
`define FDM_MODE_RESET 3'h0
`define FDM_MODE_NORMAL_REQ 3'h1
`define FDM_MODE_NORMAL 3'h2
`define FDM_MODE_STOP 3'h3
`define FDM_MODE_SLEEP 3'h4

// Reset values.
`define FDM_INT_MASK_RST 32'h0000_0000
`define FDM_MODE_CTRL_RST 32'h0000_0001

// Timing: clock rate and documented times.
`define FDM_CLK_HZ 125000000
`define FDM_TX_STUCK_MS 1000
`define FDM_NORMAL_REQ_MS 150
`define FDM_WD_FALLBACK_MS 150
`define FDM_CYCLES_PER_MS (`FDM_CLK_HZ / 1000)
`define FDM_TX_STUCK_CYC (`FDM_TX_STUCK_MS * `FDM_CYCLES_PER_MS)
`define FDM_NORMAL_REQ_CYC (`FDM_NORMAL_REQ_MS * `FDM_CYCLES_PER_MS)
`define FDM_WD_FALLBACK_CYC (`FDM_WD_FALLBACK_MS * `FDM_CYCLES_PER_MS)

`endif

//--- fdm_sync.v
/*
 * Two-flop synchroniser for a bus of asynchronous level inputs.
 * Assumes the inputs are slow levels; multi-bit values are not coherent.
 */
module fdm_sync #(
	parameter WIDTH = 16
) (
	input wire clk_in,
	input wire rst_n_in,
	input wire [WIDTH-1:0] d_in,
	output wire [WIDTH-1:0] q_out
);

	reg [WIDTH-1:0] meta_r;
	reg [WIDTH-1:0] sync_r;

	// First stage feeds only the second stage.
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_r <= {WIDTH{1'b0}};
			sync_r <= {WIDTH{1'b0}};
		end else begin
			meta_r <= d_in;
			sync_r <= meta_r;
		end
	end

	assign q_out = sync_r;

endmodule

//--- fdm_timer.v
/*
 * Counts cycles while run_in is high and flags when limit_in is reached.
 * Assumes run_in comes from the same clock domain.
 */
module fdm_timer #(
	parameter WIDTH = 28
) (
	input wire clk_in,
	input wire rst_n_in,
	input wire run_in,
	input wire [WIDTH-1:0] limit_in,
	output wire expired_out,
	output wire [WIDTH-1:0] count_out
);

	reg [WIDTH-1:0] count_r;

	// Saturates at the limit so a long stall does not wrap back.
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count_r <= {WIDTH{1'b0}};
		end else if (!run_in) begin
			count_r <= {WIDTH{1'b0}};
		end else if (count_r < limit_in) begin
			count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	assign expired_out = run_in && (count_r >= limit_in);
	assign count_out = count_r;

endmodule

//--- fdm_top.v
/*
 * Fault detection manager: takes comparator and timer levels, applies the
 * shutdown actions, keeps status flags and interrupt source, drives the
 * active-low host interrupt and a level event interrupt, over AHB-Lite.
 * Assumes all fault inputs are asynchronous levels and one AHB-Lite master.
 */
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`include "fdm_regs.vh"

//Contract
//- Normal/NormalReq: supply over flag bit3, under bit2, source 0101, interrupt.
//- Outside low power, 115C sets warning bit1, code 0101, clears when gone.
//- 170C shuts regulator, resets, then Sleep, no flag or interrupt.
//- Regulator undervoltage resets except Sleep; in Reset without supply-under goes Sleep.
//- Receive pin short shuts LIN transmitter, sets LIN status bit3.
//- Transmit low over 1.0 s shuts transmitter, sets bit2, code 0100.
//- LIN driver overheat shuts transmitter, sets LIN status bit1.
//- High-side overheat turns both off, code 0010, until gone and control written.
//- High-side thermal shutdown sets all open-load and current-limit flags.
//- Normal/NormalReq: open load sets bit1/bit3, clears when gone.
//- Current limit keeps driver on, sets bit0/bit2.
//- Floating watchdog pin uses 150 ms fallback, sets error bit2 until fixed.
//- Masked fault keeps interrupt high and sets no source flag.
//- Interrupts only in Normal, Normal Request and Stop.
//- Normal with shutdown enable, overvoltage turns high-side drivers off until gone and control written.
//- Normal Request not left within 150 ms enters Reset, resets host.
//- Watchdog clear in closed half or timeout resets host.
//- Transmitter re-enabled only when fault gone and transmit input recessive.
module fdm_top #(
	parameter TX_STUCK_CYC = `FDM_TX_STUCK_CYC,
	parameter NORMAL_REQ_CYC = `FDM_NORMAL_REQ_CYC,
	parameter WD_FALLBACK_CYC = `FDM_WD_FALLBACK_CYC
) (
	input wire MCLK_IN,
	input wire RST_N_IN,
	input wire HSEL_IN,
	input wire [31:0] HADDR_IN,
	input wire [1:0] HTRANS_IN,
	input wire HWRITE_IN,
	input wire [2:0] HSIZE_IN,
	input wire [31:0] HWDATA_IN,
	input wire HREADY_IN,
	output reg [31:0] HRDATA_OUT,
	output reg HREADYOUT_OUT,
	output reg HRESP_OUT,
	input wire BATTERY_LOW_IN,
	input wire SUPPLY_OVER_IN,
	input wire SUPPLY_UNDER_IN,
	input wire REG_UNDER_IN,
	input wire REG_WARN_TEMP_IN,
	input wire REG_SHUT_TEMP_IN,
	input wire RX_SHORT_IN,
	input wire TX_DATA_IN,
	input wire LIN_HOT_IN,
	input wire HS_HOT_IN,
	input wire [1:0] HS_OPEN_IN,
	input wire [1:0] HS_CURLIM_IN,
	input wire WD_CFG_FLOAT_IN,
	output reg LIN_TX_EN_OUT,
	output reg [1:0] HS_DRIVE_OUT,
	output reg REGULATOR_EN_OUT,
	output reg HOST_RST_N_OUT,
	output reg INT_N_OUT,
	output reg IRQ_OUT,
	output reg [2:0] MODE_OUT
);

	localparam ST_RESET = `FDM_MODE_RESET;
	localparam ST_NREQ = `FDM_MODE_NORMAL_REQ;
	localparam ST_NORMAL = `FDM_MODE_NORMAL;
	localparam ST_STOP = `FDM_MODE_STOP;
	localparam ST_SLEEP = `FDM_MODE_SLEEP;
	localparam [27:0] TX_LIM = TX_STUCK_CYC[27:0];
	localparam [27:0] NREQ_LIM = NORMAL_REQ_CYC[27:0];
	localparam [27:0] WD_LIM = WD_FALLBACK_CYC[27:0];

	reg rst_meta_r;
	reg rst_sync_r;
	wire rst_n;
	wire [15:0] raw;
	wire [15:0] syn;

	// Reset release through two flops; assertion stays asynchronous.
	always @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end
	assign rst_n = rst_sync_r;

	// Transmit input travels inverted so the cleared synchroniser reads as recessive.
	assign raw = {BATTERY_LOW_IN, SUPPLY_OVER_IN, SUPPLY_UNDER_IN, REG_UNDER_IN,
		REG_WARN_TEMP_IN, REG_SHUT_TEMP_IN, RX_SHORT_IN, ~TX_DATA_IN, LIN_HOT_IN,
		HS_HOT_IN, HS_OPEN_IN, HS_CURLIM_IN, WD_CFG_FLOAT_IN, 1'b0};

	fdm_sync #(.WIDTH(16)) u_sync (
		.clk_in(MCLK_IN),
		.rst_n_in(rst_n),
		.d_in(raw),
		.q_out(syn)
	);

	wire bat_low = syn[15];
	wire sup_over = syn[14];
	wire sup_under = syn[13];
	wire reg_under = syn[12];
	wire reg_warm = syn[11];
	wire reg_hot = syn[10];
	wire rx_short = syn[9];
	wire tx_data = !syn[8];
	wire lin_hot = syn[7];
	wire hs_hot = syn[6];
	wire [1:0] hs_open = syn[5:4];
	wire [1:0] hs_cur = syn[3:2];
	wire wd_float = syn[1];

	reg [2:0] mode_r;
	reg [2:0] mode_nxt;
	reg [3:0] sup_stat_r;
	reg [3:0] lin_stat_r;
	reg [3:0] hs_stat_r;
	reg [3:0] wd_stat_r;
	reg [3:0] src_r;
	reg [2:0] mask_r;
	reg [1:0] hs_ctrl_r;
	reg hv_en_r;
	reg hs_latch_r;
	reg lin_off_r;
	reg [2:0] evt_r;
	reg [2:0] evt_mask_r;
	reg wd_clear_r;
	reg wd_timeout_r;
	reg [2:0] mode_req_r;
	reg mode_req_v_r;
	reg sleep_after_r;

	// AHB-Lite address-phase capture.
	reg ph_wr_r;
	reg ph_rd_r;
	reg [7:0] ph_addr_r;
	wire take = HSEL_IN && HREADY_IN && HTRANS_IN[1];
	wire wr = ph_wr_r;
	wire [31:0] wd = HWDATA_IN;

	function hit;
		input [7:0] a;
		input [7:0] ofs;
		begin
			hit = (a == ofs);
		end
	endfunction

	wire wr_hsctrl = wr && hit(ph_addr_r, `FDM_HIGH_SIDE_CTRL_OFS);
	wire rd_lin = ph_rd_r && hit(ph_addr_r, `FDM_LIN_STATUS_OFS);
	wire low_power = (mode_r == ST_STOP) || (mode_r == ST_SLEEP);
	wire normalish = (mode_r == ST_NORMAL) || (mode_r == ST_NREQ);
	wire int_mode = normalish || (mode_r == ST_STOP);

	// Transmit stuck-low timer and mode timers.
	wire tx_stuck;
	wire nreq_exp;
	wire wd_exp;
	wire [27:0] wd_cnt;
	fdm_timer #(.WIDTH(28)) u_tx (
		.clk_in(MCLK_IN), .rst_n_in(rst_n), .run_in(!tx_data),
		.limit_in(TX_LIM), .expired_out(tx_stuck), .count_out()
	);
	fdm_timer #(.WIDTH(28)) u_nreq (
		.clk_in(MCLK_IN), .rst_n_in(rst_n), .run_in(mode_r == ST_NREQ),
		.limit_in(NREQ_LIM), .expired_out(nreq_exp), .count_out()
	);
	fdm_timer #(.WIDTH(28)) u_wd (
		.clk_in(MCLK_IN), .rst_n_in(rst_n),
		.run_in(mode_r == ST_NORMAL && !wd_clear_r), .limit_in(WD_LIM),
		.expired_out(wd_exp), .count_out(wd_cnt)
	);
	// Window closed during the first half of the period.
	wire wd_bad = wd_exp || (wd_clear_r && (wd_cnt < (WD_LIM >> 1)));

	// Fault events feeding the source code and interrupts.
	wire ev_sup = int_mode && mask_r[`FDM_MASK_SUPPLY_BIT] &&
		((normalish && (sup_over || sup_under)) || (!low_power && reg_warm));
	wire ev_lin = int_mode && mask_r[`FDM_MASK_LIN_BIT] &&
		(tx_stuck || rx_short || lin_hot);
	wire ev_hs = int_mode && mask_r[`FDM_MASK_HS_BIT] && hs_hot;

	// Operating mode sequencing.
	always @* begin
		mode_nxt = mode_r;
		case (mode_r)
			ST_RESET: begin
				if (reg_under && !sup_stat_r[`FDM_SUPPLY_UNDER_BIT]) begin
					mode_nxt = ST_SLEEP;
				end else if (sleep_after_r) begin
					mode_nxt = ST_SLEEP;
				end else if (!reg_under) begin
					mode_nxt = ST_NREQ;
				end
			end
			ST_NREQ, ST_NORMAL, ST_STOP: begin
				if (reg_hot || reg_under) begin
					mode_nxt = ST_RESET;
				end else if (mode_r == ST_NREQ && nreq_exp) begin
					mode_nxt = ST_RESET;
				end else if (mode_r == ST_NORMAL && wd_bad) begin
					mode_nxt = ST_RESET;
				end else if (mode_req_v_r && mode_req_r != ST_RESET) begin
					mode_nxt = mode_req_r;
				end
			end
			ST_SLEEP: begin
				if (mode_req_v_r && mode_req_r == ST_NREQ) begin
					mode_nxt = ST_RESET;
				end
			end
			default: begin
				mode_nxt = ST_RESET;
			end
		endcase
	end

	// Mode register, mode requests and shutdown latches.
	always @(posedge MCLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			mode_r <= ST_RESET;
			mode_req_r <= ST_RESET;
			mode_req_v_r <= 1'b0;
			wd_clear_r <= 1'b0;
			hv_en_r <= 1'b0;
			sleep_after_r <= 1'b0;
			hs_latch_r <= 1'b0;
			lin_off_r <= 1'b0;
			hs_ctrl_r <= 2'h0;
			mask_r <= 3'h0;
			evt_mask_r <= 3'h0;
			wd_timeout_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			mode_req_v_r <= 1'b0;
			wd_clear_r <= 1'b0;
			if (reg_hot) begin
				sleep_after_r <= 1'b1;
			end else if (mode_r == ST_SLEEP) begin
				sleep_after_r <= 1'b0;
			end
			if (mode_r == ST_NORMAL && wd_bad) begin
				wd_timeout_r <= 1'b1;
			end else if (mode_r == ST_NORMAL) begin
				wd_timeout_r <= 1'b0;
			end
			// High-side off stays latched until gone and control rewritten.
			if (hs_hot || (mode_r == ST_NORMAL && hv_en_r && sup_over)) begin
				hs_latch_r <= 1'b1;
			end else if (wr_hsctrl) begin
				hs_latch_r <= 1'b0;
			end
			if (tx_stuck || rx_short || lin_hot) begin
				lin_off_r <= 1'b1;
			end else if (tx_data) begin
				lin_off_r <= 1'b0;
			end
			if (wr && hit(ph_addr_r, `FDM_MODE_CTRL_OFS)) begin
				mode_req_r <= wd[`FDM_MODE_LSB+2:`FDM_MODE_LSB];
				mode_req_v_r <= 1'b1;
				hv_en_r <= wd[`FDM_HV_SHUTDOWN_EN_BIT];
				wd_clear_r <= (mode_r == ST_NORMAL);
			end
			if (wr_hsctrl) begin
				hs_ctrl_r <= wd[1:0];
			end
			if (wr && hit(ph_addr_r, `FDM_INT_MASK_OFS)) begin
				mask_r <= wd[2:0];
			end
			if (wr && hit(ph_addr_r, `FDM_EVENT_MASK_OFS)) begin
				evt_mask_r <= wd[2:0];
			end
		end
	end

	// Status flags: live conditions, with sticky LIN bits cleared on read.
	always @(posedge MCLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			sup_stat_r <= 4'h0;
			lin_stat_r <= 4'h0;
			hs_stat_r <= 4'h0;
			wd_stat_r <= 4'h0;
			src_r <= `FDM_SRC_NONE;
			evt_r <= 3'h0;
		end else begin
			sup_stat_r[`FDM_BATTERY_LOSS_BIT] <= bat_low;
			sup_stat_r[`FDM_REG_THERMAL_WARN_BIT] <= !low_power && reg_warm;
			sup_stat_r[`FDM_SUPPLY_UNDER_BIT] <= normalish && sup_under;
			sup_stat_r[`FDM_SUPPLY_OVER_BIT] <= normalish && sup_over;
			lin_stat_r[0] <= 1'b0;
			lin_stat_r[`FDM_LIN_OVERHEAT_BIT] <= lin_hot;
			// Set wins over a read clear in the same cycle.
			if (tx_stuck) begin
				lin_stat_r[`FDM_TX_STUCK_BIT] <= 1'b1;
			end else if (rd_lin && tx_data) begin
				lin_stat_r[`FDM_TX_STUCK_BIT] <= 1'b0;
			end
			if (rx_short) begin
				lin_stat_r[`FDM_RX_SHORT_BIT] <= 1'b1;
			end else if (rd_lin) begin
				lin_stat_r[`FDM_RX_SHORT_BIT] <= 1'b0;
			end
			if (hs_hot) begin
				hs_stat_r <= 4'hf;
			end else begin
				hs_stat_r[`FDM_D1_OPEN_BIT] <= normalish && hs_open[0];
				hs_stat_r[`FDM_D2_OPEN_BIT] <= normalish && hs_open[1];
				hs_stat_r[`FDM_D1_CURLIM_BIT] <= hs_cur[0];
				hs_stat_r[`FDM_D2_CURLIM_BIT] <= hs_cur[1];
			end
			wd_stat_r <= 4'h0;
			wd_stat_r[`FDM_WD_CFG_ERR_BIT] <= wd_float;
			wd_stat_r[`FDM_WD_TIMEOUT_BIT] <= wd_timeout_r;
			// Source code: highest priority unmasked event; no set while masked.
			if (ev_sup) begin
				src_r <= `FDM_SRC_SUPPLY;
			end else if (ev_lin) begin
				src_r <= `FDM_SRC_LIN;
			end else if (ev_hs) begin
				src_r <= `FDM_SRC_HS;
			end else begin
				src_r <= `FDM_SRC_NONE;
			end
			// Sticky event bits; a new event wins over a write-one clear.
			if (wr && hit(ph_addr_r, `FDM_EVENT_STATUS_OFS)) begin
				evt_r <= (evt_r & ~wd[2:0]) | {ev_sup, ev_lin, ev_hs};
			end else begin
				evt_r <= evt_r | {ev_sup, ev_lin, ev_hs};
			end
		end
	end

	// Output pins, all registered.
	always @(posedge MCLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			LIN_TX_EN_OUT <= 1'b0;
			HS_DRIVE_OUT <= 2'h0;
			REGULATOR_EN_OUT <= 1'b0;
			HOST_RST_N_OUT <= 1'b0;
			INT_N_OUT <= 1'b1;
			IRQ_OUT <= 1'b0;
			MODE_OUT <= ST_RESET;
		end else begin
			LIN_TX_EN_OUT <= normalish && !lin_off_r && !(tx_stuck || rx_short || lin_hot);
			HS_DRIVE_OUT <= (hs_latch_r || hs_hot) ? 2'h0 : hs_ctrl_r;
			REGULATOR_EN_OUT <= !reg_hot && mode_r != ST_SLEEP;
			HOST_RST_N_OUT <= mode_r != ST_RESET && !reg_hot
				&& !(reg_under && mode_r != ST_SLEEP);
			INT_N_OUT <= !(ev_sup || ev_lin || ev_hs);
			IRQ_OUT <= |(evt_r & evt_mask_r);
			MODE_OUT <= mode_r;
		end
	end

	// AHB-Lite slave: zero wait states, always OKAY.
	always @(posedge MCLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			ph_wr_r <= 1'b0;
			ph_rd_r <= 1'b0;
			ph_addr_r <= 8'h00;
			HRDATA_OUT <= 32'h0000_0000;
			HREADYOUT_OUT <= 1'b1;
			HRESP_OUT <= 1'b0;
		end else begin
			ph_wr_r <= take && HWRITE_IN;
			ph_rd_r <= take && !HWRITE_IN;
			if (take) begin
				ph_addr_r <= HADDR_IN[7:0];
			end
			HRDATA_OUT <= 32'h0000_0000;
			if (take && !HWRITE_IN) begin
				case (HADDR_IN[7:0])
					`FDM_SUPPLY_STATUS_OFS: HRDATA_OUT <= {28'h0, sup_stat_r};
					`FDM_LIN_STATUS_OFS: HRDATA_OUT <= {28'h0, lin_stat_r};
					`FDM_HIGH_SIDE_STATUS_OFS: HRDATA_OUT <= {28'h0, hs_stat_r};
					`FDM_WATCHDOG_STATUS_OFS: HRDATA_OUT <= {28'h0, wd_stat_r};
					`FDM_INT_SOURCE_OFS: HRDATA_OUT <= {28'h0, src_r};
					`FDM_INT_MASK_OFS: HRDATA_OUT <= {29'h0, mask_r};
					`FDM_HIGH_SIDE_CTRL_OFS: HRDATA_OUT <= {30'h0, hs_ctrl_r};
					`FDM_MODE_CTRL_OFS: HRDATA_OUT <= {28'h0, hv_en_r, mode_r};
					`FDM_EVENT_STATUS_OFS: HRDATA_OUT <= {29'h0, evt_r};
					`FDM_EVENT_MASK_OFS: HRDATA_OUT <= {29'h0, evt_mask_r};
					`FDM_STATE_OFS: HRDATA_OUT <= {28'h0, lin_off_r, mode_r};
					default: HRDATA_OUT <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule

//--- fdm_assertions.sv
/*
 * Concurrent checks on the fault detection manager's ports.
 * Assumes it is bound to the top module and sees only its ports.
 */
module fdm_assertions (
	input logic MCLK_IN,
	input logic RST_N_IN,
	input logic HSEL_IN,
	input logic [31:0] HADDR_IN,
	input logic [1:0] HTRANS_IN,
	input logic HWRITE_IN,
	input logic HREADY_IN,
	input logic [31:0] HRDATA_OUT,
	input logic RX_SHORT_IN,
	input logic TX_DATA_IN,
	input logic LIN_HOT_IN,
	input logic HS_HOT_IN,
	input logic REG_SHUT_TEMP_IN,
	input logic LIN_TX_EN_OUT,
	input logic [1:0] HS_DRIVE_OUT,
	input logic REGULATOR_EN_OUT,
	input logic INT_N_OUT,
	input logic [2:0] MODE_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	// Everything runs on the core clock; checks pause while the reset pin is low.
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!RST_N_IN);
	lin_rx_shut_a: assert property (
		RX_SHORT_IN [*5] |-> !LIN_TX_EN_OUT)
		else $error("transmitter on during receive short");
	lin_hot_shut_a: assert property (
		LIN_HOT_IN [*5] |-> !LIN_TX_EN_OUT)
		else $error("transmitter on during driver overheat");
	hs_hot_off_a: assert property (
		HS_HOT_IN [*5] |-> HS_DRIVE_OUT == 2'h0)
		else $error("high-side driver on during overheat");
	reg_shut_off_a: assert property (
		REG_SHUT_TEMP_IN [*5] |-> !REGULATOR_EN_OUT)
		else $error("regulator on during overtemperature");
	int_mode_a: assert property (
		$fell(INT_N_OUT) |-> MODE_OUT inside {3'h1, 3'h2, 3'h3})
		else $error("interrupt raised in a quiet mode");
	// The transmitter comes back only once the line is recessive and faults are gone.
	tx_restore_a: assert property (
		$rose(LIN_TX_EN_OUT) |-> $past(TX_DATA_IN, 3) && !$past(RX_SHORT_IN, 3)
			&& !$past(LIN_HOT_IN, 3))
		else $error("transmitter re-enabled too early");
	idle_rdata_a: assert property (
		!(HSEL_IN && HREADY_IN && HTRANS_IN[1] && !HWRITE_IN) |=> HRDATA_OUT == 32'h0)
		else $error("read data outside a read data phase");
	unmapped_zero_a: assert property (
		HSEL_IN && HREADY_IN && HTRANS_IN[1] && !HWRITE_IN && HADDR_IN[7:0] > 8'h28
			|=> HRDATA_OUT == 32'h0)
		else $error("unmapped read returned data");
endmodule

//--- fdm_host.sv
/*
 * Host model: an AHB-Lite master doing single word transfers, and the
 * mode service that keeps the watchdog content.
 * Assumes one slave whose ready output is the bus ready.
 */
module fdm_host (
	input logic clk_in,
	input logic hready_in,
	input logic [31:0] hrdata_in,
	output logic hsel_out,
	output logic [31:0] haddr_out,
	output logic [1:0] htrans_out,
	output logic hwrite_out,
	output logic [2:0] hsize_out,
	output logic [31:0] hwdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	int cyc = 0;
	int last_clr = 0;
	// Bus starts idle with a word size.
	initial begin
		hsel_out = 1'b0;
		haddr_out = 32'h0;
		htrans_out = 2'h0;
		hwrite_out = 1'b0;
		hsize_out = 3'h2;
		hwdata_out = 32'h0;
	end
	// Free cycle count used to place watchdog clears.
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
	end
	// One transfer; called just after a rising edge.
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel_out <= 1'b1;
		htrans_out <= 2'h2;
		haddr_out <= {24'h0, a};
		hwrite_out <= wr;
		do @(posedge clk_in); while (hready_in !== 1'b1);
		hsel_out <= 1'b0;
		htrans_out <= 2'h0;
		hwdata_out <= d;
		do @(posedge clk_in); while (hready_in !== 1'b1);
		q = hrdata_in;
	endtask
	// Mode write; it also starts a new watchdog period.
	task automatic enter(input logic [31:0] mode_w);
		logic [31:0] q;
		xfer(1'b1, 8'h1c, mode_w, q);
		last_clr = cyc;
	endtask
	// A clear early in the period resets the host, so wait for the open half.
	task automatic kick(input logic [31:0] mode_w);
		while (cyc - last_clr < 40) @(posedge clk_in);
		enter(mode_w);
	endtask
endmodule

//--- fdm_top_tb.sv
/*
 * Self-checking bench for the fault detection manager: faults, masks,
 * events and host service. Assumes shortened timer parameters.
 */
module fdm_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [6:0] flt = 7'h0;
	logic reg_shut = 1'b0;
	logic tx_data = 1'b1;
	logic [1:0] hs_open = 2'h0;
	logic [1:0] hs_cl = 2'h0;
	logic bat_low = 1'b0;
	logic reg_under = 1'b0;
	logic [1:0] o;
	logic [1:0] c;
	logic [31:0] q;
	wire hsel, hwrite, hready, hresp, lin_tx, reg_en, host_rst_n, int_n, irq;
	wire [31:0] haddr, hwdata, hrdata;
	wire [1:0] htrans, hs_drive;
	wire [2:0] hsize, mode;
	int n_fail = 0;
	int comparisons = 0;
	int cycles = 0;
	int seed;
	int n_rst = 0;
	int r0;
	// Cycles with the host held in reset, so resets can be seen after the fact.
	always @(posedge mclk) begin
		n_rst <= n_rst + (host_rst_n === 1'b0);
	end
	// Per fault: status offset, status value, source code.
	logic [7:0] st_ofs [7] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h04, 8'h08, 8'h0c};
	logic [31:0] st_val [7] = '{32'h8, 32'h4, 32'h2, 32'h8, 32'h2, 32'hf, 32'h4};
	logic [3:0] src_val [7] = '{4'h5, 4'h5, 4'h5, 4'h4, 4'h4, 4'h2, 4'h0};
	fdm_top #(.TX_STUCK_CYC(200), .NORMAL_REQ_CYC(100), .WD_FALLBACK_CYC(64)) dut_u (
		.MCLK_IN(mclk), .RST_N_IN(rst_n), .HSEL_IN(hsel), .HADDR_IN(haddr),
		.HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata),
		.HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
		.HRESP_OUT(hresp), .BATTERY_LOW_IN(bat_low), .SUPPLY_OVER_IN(flt[0]),
		.SUPPLY_UNDER_IN(flt[1]), .REG_UNDER_IN(reg_under), .REG_WARN_TEMP_IN(flt[2]),
		.REG_SHUT_TEMP_IN(reg_shut), .RX_SHORT_IN(flt[3]), .TX_DATA_IN(tx_data),
		.LIN_HOT_IN(flt[4]), .HS_HOT_IN(flt[5]), .HS_OPEN_IN(hs_open),
		.HS_CURLIM_IN(hs_cl), .WD_CFG_FLOAT_IN(flt[6]), .LIN_TX_EN_OUT(lin_tx),
		.HS_DRIVE_OUT(hs_drive), .REGULATOR_EN_OUT(reg_en), .HOST_RST_N_OUT(host_rst_n),
		.INT_N_OUT(int_n), .IRQ_OUT(irq), .MODE_OUT(mode));
	fdm_host hst_u (.clk_in(mclk), .hready_in(hready), .hrdata_in(hrdata),
		.hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite),
		.hsize_out(hsize), .hwdata_out(hwdata));
	// 125 MHz core clock.
	initial begin
		forever #4 mclk = ~mclk;
	end
	task automatic end_of_test();
		if (n_fail == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// A hung handshake ends the run as a failure.
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			end_of_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		hst_u.xfer(1'b0, a, 32'h0, q);
		chk(q, exp);
		chk(hresp, 1'b0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		hst_u.xfer(1'b1, a, d, q);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
	endtask
	function automatic logic [31:0] hs_exp(input logic [1:0] op, input logic [1:0] cl);
		return {28'h0, op[1], cl[1], op[0], cl[0]};
	endfunction
	// Event group of a source code: high-side bit 0, LIN bit 1, supply bit 2.
	function automatic logic [3:0] ev_of(input logic [3:0] s);
		return (s == 4'h5) ? 4'h4 : (s == 4'h4) ? 4'h2 : (s == 4'h2) ? 4'h1 : 4'h0;
	endfunction
	// The event level holds until its status bit is written with a one.
	task automatic evclr(input logic [3:0] ev);
		chk(irq, ev != 4'h0);
		rd(8'h20, {28'h0, ev});
		wr(8'h20, {28'h0, ev});
		idle(4);
		chk(irq, 1'b0);
	endtask
	// Main sequence.
	initial begin
		seed = $urandom(84);
		idle(2);
		rst_n <= 1'b1;
		while (mode !== 3'h1) @(posedge mclk);
		rd(8'h14, 32'h0);
		hst_u.enter(32'ha);
		wr(8'h14, 32'h7);
		wr(8'h24, 32'h7);
		wr(8'h18, 32'h3);
		idle(4);
		rd(8'h14, 32'h7);
		chk(mode, 3'h2);
		chk(hs_drive, 2'h3);
		rd(8'h1c, 32'ha);
		rd(8'h28, 32'h2);
		for (int i = 0; i < 7; i++) begin
			hst_u.kick(32'ha);
			flt[i] <= 1'b1;
			idle(8);
			rd(st_ofs[i], st_val[i]);
			rd(8'h10, {28'h0, src_val[i]});
			chk(int_n, src_val[i] == 4'h0);
			chk(lin_tx, !(i == 3 || i == 4));
			chk(hs_drive, (i == 0 || i == 5) ? 2'h0 : 2'h3);
			hst_u.kick(32'ha);
			flt[i] <= 1'b0;
			idle(8);
			rd(st_ofs[i], (i == 3) ? 32'h8 : 32'h0);
			chk(int_n, 1'b1);
			chk(lin_tx, 1'b1);
			chk(hs_drive, (i == 0 || i == 5) ? 2'h0 : 2'h3);
			wr(8'h18, 32'h3);
			idle(6);
			chk(hs_drive, 2'h3);
			evclr(ev_of(src_val[i]));
		end
		for (int k = 0; k < 4; k++) begin
			hst_u.kick(32'ha);
			o = (k == 0) ? 2'h3 : 2'($urandom);
			c = (k == 0) ? 2'h3 : 2'($urandom);
			hs_open <= o;
			hs_cl <= c;
			idle(8);
			rd(8'h08, hs_exp(o, c));
			chk(hs_drive, 2'h3);
			chk(int_n, 1'b1);
		end
		hs_open <= 2'h0;
		hs_cl <= 2'h0;
		// Transmit line held dominant past the stuck limit, with service kept up.
		hst_u.kick(32'ha);
		tx_data <= 1'b0;
		repeat (6) hst_u.kick(32'ha);
		chk(lin_tx, 1'b0);
		rd(8'h04, 32'h4);
		rd(8'h10, 32'h4);
		tx_data <= 1'b1;
		idle(8);
		chk(lin_tx, 1'b1);
		rd(8'h04, 32'h4);
		rd(8'h04, 32'h0);
		evclr(4'h2);
		hst_u.kick(32'ha);
		rd(8'h3c, 32'h0);
		wr(8'h14, 32'h0);
		wr(8'h24, 32'h0);
		flt[0] <= 1'b1;
		idle(8);
		chk(int_n, 1'b1);
		rd(8'h10, 32'h0);
		chk(irq, 1'b0);
		flt[0] <= 1'b0;
		wr(8'h14, 32'h7);
		hst_u.kick(32'ha);
		// Supply loss flag, then regulator loss: host reset, Sleep, wake by request.
		bat_low <= 1'b1;
		idle(8);
		rd(8'h00, 32'h1);
		bat_low <= 1'b0;
		r0 = n_rst;
		reg_under <= 1'b1;
		idle(8);
		chk(mode, 3'h4);
		chk(n_rst > r0, 1'b1);
		reg_under <= 1'b0;
		wr(8'h1c, 32'h1);
		while (mode !== 3'h1) @(posedge mclk);
		hst_u.enter(32'ha);
		// Service stopped: watchdog timeout, then Normal Request left to time out.
		idle(80);
		rd(8'h0c, 32'h8);
		r0 = n_rst;
		idle(110);
		chk(n_rst > r0, 1'b1);
		while (mode !== 3'h1) @(posedge mclk);
		hst_u.enter(32'ha);
		idle(4);
		chk(mode, 3'h2);
		reg_shut <= 1'b1;
		idle(8);
		chk(reg_en, 1'b0);
		chk(mode, 3'h4);
		chk(int_n, 1'b1);
		end_of_test();
	end
endmodule
bind fdm_top fdm_assertions chk_u (.MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN),
	.HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN),
	.HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT), .RX_SHORT_IN(RX_SHORT_IN),
	.TX_DATA_IN(TX_DATA_IN), .LIN_HOT_IN(LIN_HOT_IN), .HS_HOT_IN(HS_HOT_IN),
	.REG_SHUT_TEMP_IN(REG_SHUT_TEMP_IN), .LIN_TX_EN_OUT(LIN_TX_EN_OUT),
	.HS_DRIVE_OUT(HS_DRIVE_OUT), .REGULATOR_EN_OUT(REGULATOR_EN_OUT),
	.INT_N_OUT(INT_N_OUT), .MODE_OUT(MODE_OUT));
